// ===== rtl/bcc_pkg.sv
/*
 * Package for the bridge current chopper control block: timing constants,
 * level codes, gate and state types.
 * Assumes a 100 MHz system clock and 32-bit APB data.
 */
package bcc_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned BLANK_NS = 1000;
	localparam int unsigned BLANK_CYC = BLANK_NS * CLK_MHZ / 1000;
	localparam int unsigned OFF_FIXED_US = 30;
	localparam int unsigned OFF_FIXED_CYC = OFF_FIXED_US * CLK_MHZ;
	localparam int unsigned OFF_OHM_PER_US = 825;
	localparam int unsigned FAST_NUM = 5;
	localparam int unsigned FAST_DEN = 16;
	localparam int unsigned CNT_W = 24;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OFF_TIME_SET_PIN = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] LVL_100 = 2'h0;
	localparam logic [1:0] LVL_66 = 2'h1;
	localparam logic [1:0] LVL_33 = 2'h2;
	localparam logic [1:0] LVL_OFF = 2'h3;
	localparam logic [19:0] OFF_TIME_SET_PIN_RST = 20'h00000;

	typedef enum logic [1:0] {ST_ON, ST_FAST, ST_SLOW, ST_IDLE} bcc_phase_e;

	typedef struct packed {
		logic src_a;
		logic snk_a;
		logic src_b;
		logic snk_b;
	} bcc_gate_s;

	typedef struct packed {
		bcc_phase_e ph;
		logic [CNT_W-1:0] cnt;
		logic gnd_lat;
	} bcc_br_s;

	typedef struct packed {
		bcc_br_s [1:0] br;
		bcc_gate_s [1:0] gate;
		logic [1:0] [1:0] dac;
		logic [7:0] ctrl;
		logic [19:0] off_time_set_pin;
		logic sleep_prev;
		logic [31:0] prdata;
		logic pready;
	} bcc_state_s;
endpackage : bcc_pkg

// ===== rtl/bcc_chopper.sv
/*
 * Two-bridge fixed off-time current chopper with mixed decay, blanking,
 * fault shutdown, sleep and an APB register file.
 * Assumes comparator, fault and strap inputs already synchronous to clk_sys_i.
 */
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module bcc_chopper (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Bridge inputs
	input wire logic [1:0] phase_i,
	input wire logic [1:0] trip_i,
	input wire logic [1:0] zero_cur_i,
	input wire logic [1:0] gnd_short_i,
	// Off-time pin
	input wire logic off_time_strapped_i,
	input wire logic [19:0] off_time_ohms_i,
	// Faults and power
	input wire logic sleep_n_i,
	input wire logic sink_gate_regulator_fault_i,
	input wire logic over_temp_i,
	input wire logic gate_pump_reservoir_uv_i,
	input wire logic supply_undervoltage_lockout_i,
	// Gate drive and power control
	output bcc_pkg::bcc_gate_s [1:0] gate_o,
	output logic [1:0][1:0] dac_level_o,
	output logic pump_en_o,
	output logic translator_home_o
);
	bcc_pkg::bcc_state_s s_q;
	bcc_pkg::bcc_state_s s_d;
	logic [bcc_pkg::CNT_W-1:0] off_cyc;
	logic [bcc_pkg::CNT_W-1:0] fast_cyc;
	logic [bcc_pkg::CNT_W-1:0] res_cyc;
	logic [19:0] ohms;
	logic strapped;
	logic hold_off;
	logic regs_hit;

	// Software override of the strap lets the off-time be tested without pins
	assign strapped = s_q.ctrl[4] ? (s_q.off_time_set_pin == 20'h00000) : off_time_strapped_i;
	assign ohms = s_q.ctrl[4] ? s_q.off_time_set_pin : off_time_ohms_i;
	// Division is on static pin or register data only; a slow path is acceptable here
	assign res_cyc = bcc_pkg::CNT_W'(32'(ohms) * bcc_pkg::CLK_MHZ / bcc_pkg::OFF_OHM_PER_US);
	assign off_cyc = strapped ? bcc_pkg::CNT_W'(bcc_pkg::OFF_FIXED_CYC) : res_cyc;
	assign fast_cyc = bcc_pkg::CNT_W'(32'(off_cyc) * bcc_pkg::FAST_NUM / bcc_pkg::FAST_DEN);
	assign hold_off = !sleep_n_i || supply_undervoltage_lockout_i || sink_gate_regulator_fault_i
		|| over_temp_i || gate_pump_reservoir_uv_i;
	assign regs_hit = paddr_i == bcc_pkg::ADDR_CTRL || paddr_i == bcc_pkg::ADDR_OFF_TIME_SET_PIN
		|| paddr_i == bcc_pkg::ADDR_STAT;

	always_comb begin
		s_d = s_q;
		s_d.sleep_prev = sleep_n_i;
		s_d.pready = psel_i && !penable_i;
		if (psel_i && penable_i && s_q.pready && pwrite_i) begin
			if (paddr_i == bcc_pkg::ADDR_CTRL)
				s_d.ctrl = pwdata_i[7:0];
			if (paddr_i == bcc_pkg::ADDR_OFF_TIME_SET_PIN)
				s_d.off_time_set_pin = pwdata_i[19:0];
		end
		if (psel_i && !penable_i) begin
			case (paddr_i)
				bcc_pkg::ADDR_CTRL: s_d.prdata = {24'h000000, s_q.ctrl};
				bcc_pkg::ADDR_OFF_TIME_SET_PIN: s_d.prdata = {12'h000, s_q.off_time_set_pin};
				bcc_pkg::ADDR_STAT: s_d.prdata = {20'h00000, hold_off, s_q.br[1].gnd_lat,
					s_q.br[0].gnd_lat, s_q.br[1].ph, s_q.br[0].ph, s_q.gate[1], 1'b0};
				default: s_d.prdata = 32'h00000000;
			endcase
		end
		for (int b = 0; b < 2; b++) begin
			logic [1:0] lvl;
			logic dir;
			lvl = s_q.ctrl[2*b +: 2];
			dir = phase_i[b];
			s_d.dac[b] = lvl;
			// Latched until the sleep pin changes or the logic supply drops
			if (sleep_n_i != s_q.sleep_prev || supply_undervoltage_lockout_i)
				s_d.br[b].gnd_lat = 1'b0;
			else if (gnd_short_i[b])
				s_d.br[b].gnd_lat = 1'b1;
			if (s_q.br[b].cnt != '0)
				s_d.br[b].cnt = s_q.br[b].cnt - 1'b1;
			case (s_q.br[b].ph)
				bcc_pkg::ST_IDLE: begin
					s_d.br[b].ph = bcc_pkg::ST_ON;
					// Counter runs down to zero inclusive, so load one less
					s_d.br[b].cnt = bcc_pkg::CNT_W'(bcc_pkg::BLANK_CYC - 1);
				end
				bcc_pkg::ST_ON: begin
					// Blanking hides recovery spikes; shorted load still trips after it
					if (s_q.br[b].cnt == '0 && trip_i[b]) begin
						s_d.br[b].ph = bcc_pkg::ST_FAST;
						s_d.br[b].cnt = fast_cyc - 1'b1;
					end
				end
				bcc_pkg::ST_FAST: begin
					if (s_q.br[b].cnt == '0) begin
						s_d.br[b].ph = bcc_pkg::ST_SLOW;
						s_d.br[b].cnt = off_cyc - fast_cyc - 1'b1;
					end
				end
				bcc_pkg::ST_SLOW: begin
					if (s_q.br[b].cnt == '0) begin
						s_d.br[b].ph = bcc_pkg::ST_ON;
						s_d.br[b].cnt = bcc_pkg::CNT_W'(bcc_pkg::BLANK_CYC - 1);
					end
				end
				default: s_d.br[b].ph = bcc_pkg::ST_IDLE;
			endcase
			s_d.gate[b] = '0;
			case (s_d.br[b].ph)
				bcc_pkg::ST_ON: begin
					s_d.gate[b].src_a = dir;
					s_d.gate[b].snk_b = dir;
					s_d.gate[b].src_b = !dir;
					s_d.gate[b].snk_a = !dir;
				end
				bcc_pkg::ST_FAST: begin
					// Reverse pair drives current back; dropped at zero current
					if (!zero_cur_i[b]) begin
						s_d.gate[b].src_b = dir;
						s_d.gate[b].snk_a = dir;
						s_d.gate[b].src_a = !dir;
						s_d.gate[b].snk_b = !dir;
					end
				end
				bcc_pkg::ST_SLOW: begin
					if (!zero_cur_i[b]) begin
						s_d.gate[b].snk_a = 1'b1;
						s_d.gate[b].snk_b = 1'b1;
					end
				end
				default: s_d.gate[b] = '0;
			endcase
			if (lvl == bcc_pkg::LVL_OFF || hold_off || s_d.br[b].gnd_lat) begin
				s_d.gate[b] = '0;
				s_d.br[b].ph = bcc_pkg::ST_IDLE;
				s_d.br[b].cnt = '0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
			s_q.ctrl <= bcc_pkg::CTRL_RST;
			s_q.off_time_set_pin <= bcc_pkg::OFF_TIME_SET_PIN_RST;
			s_q.br[0].ph <= bcc_pkg::ST_IDLE;
			s_q.br[1].ph <= bcc_pkg::ST_IDLE;
			s_q.sleep_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign gate_o = s_q.gate;
	assign dac_level_o = s_q.dac;
	assign prdata_o = s_q.prdata;
	assign pready_o = s_q.pready;
	assign pslverr_o = 1'b0;
	// Pump follows sleep; home held during lockout
	logic pump_q;
	logic home_q;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pump_q <= 1'b0;
			home_q <= 1'b1;
		end else begin
			pump_q <= sleep_n_i;
			home_q <= supply_undervoltage_lockout_i;
		end
	end
	assign pump_en_o = pump_q;
	assign translator_home_o = home_q;
	logic unused_hit;
	assign unused_hit = regs_hit;
endmodule : bcc_chopper

`default_nettype wire

// ===== verification/bcc_properties.sv
/* Port checker for the chopper: fault gating, blanking and decay spans.
   Assumes phase_i[0] held high; bound to bcc_chopper below. */
`timescale 1ns/100ps
`default_nettype none
module bcc_properties (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Watched inputs
	input wire logic off_time_strapped_i,
	input wire logic sleep_n_i,
	input wire logic sink_gate_regulator_fault_i,
	input wire logic over_temp_i,
	input wire logic gate_pump_reservoir_uv_i,
	input wire logic supply_undervoltage_lockout_i,
	// Watched outputs
	input wire bcc_pkg::bcc_gate_s [1:0] gate_o,
	input wire logic [1:0][1:0] dac_level_o,
	input wire logic pump_en_o,
	input wire logic translator_home_o
);
	logic [3:0] prev_q;
	logic [11:0] cnt_q;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Hold counter may wrap on long holds; only decay spans and the blanking minimum are judged
	always_ff @(posedge clk_sys_i) begin
		prev_q <= gate_o[0];
		cnt_q <= (gate_o[0] != prev_q) ? 12'h000 : cnt_q + 12'h001;
	end
	sequence s_fast_end;
		prev_q == 4'h6 && gate_o[0] != 4'h6 && gate_o[0] != 4'h0 && off_time_strapped_i;
	endsequence
	sequence s_slow_end;
		prev_q == 4'h5 && gate_o[0] != 4'h5 && gate_o[0] != 4'h0 && off_time_strapped_i;
	endsequence
	a_fault_off: assert property (sink_gate_regulator_fault_i || over_temp_i
		|| gate_pump_reservoir_uv_i |=> gate_o == '0) else $error("fault gates");
	a_lockout_home: assert property (supply_undervoltage_lockout_i
		|=> translator_home_o && gate_o == '0) else $error("lockout");
	a_sleep_off: assert property (!sleep_n_i |=> !pump_en_o && gate_o == '0)
		else $error("sleep");
	a_level_off: assert property (dac_level_o[0] == 2'h3 && $past(dac_level_o[0]) == 2'h3
		|-> gate_o[0] == '0) else $error("level off");
	a_diag_pair: assert property (gate_o[0].src_a |-> gate_o[0] == 4'h9)
		else $error("diagonal");
	a_blank_hold: assert property (prev_q == 4'h9 && gate_o[0] == 4'h6 |-> cnt_q >= 12'h063)
		else $error("blanking");
	a_fast_span: assert property (s_fast_end |-> cnt_q == 12'h3a8 && gate_o[0] == 4'h5)
		else $error("fast span");
	a_slow_span: assert property (s_slow_end |-> cnt_q == 12'h80e && gate_o[0] == 4'h9)
		else $error("slow span");
endmodule : bcc_properties
bind bcc_chopper bcc_properties i_props (.clk_sys_i, .rst_n_i, .off_time_strapped_i, .sleep_n_i,
	.sink_gate_regulator_fault_i, .over_temp_i, .gate_pump_reservoir_uv_i,
	.supply_undervoltage_lockout_i, .gate_o, .dac_level_o, .pump_en_o, .translator_home_o);
`default_nettype wire

// ===== verification/bcc_motor_model.sv
/* Winding and sense model: the comparator trips RAMP cycles into drive.
   Assumes gates as driven by the chopper. */
`timescale 1ns/100ps
`default_nettype none
module bcc_motor_model #(parameter int RAMP = 40) (
	// Clock
	input wire logic clk_sys_i,
	// Bridge side
	input wire bcc_pkg::bcc_gate_s [1:0] gate_i,
	input wire logic [1:0] phase_i,
	output logic [1:0] trip_o,
	output logic [1:0] zero_cur_o
);
	int cnt [2] = '{0, 0};
	always @(posedge clk_sys_i) begin
		for (int b = 0; b < 2; b++) begin
			// Ramp shorter than blanking: a shorted load trips at once
			cnt[b] <= (gate_i[b] == (phase_i[b] ? 4'h9 : 4'h6)) ? cnt[b] + 1 : 0;
		end
	end
	assign trip_o = {cnt[1] >= RAMP, cnt[0] >= RAMP};
	assign zero_cur_o = {gate_i[1] == 4'h0, gate_i[0] == 4'h0};
endmodule : bcc_motor_model
`default_nettype wire

// ===== verification/tb_top.sv
/* Chopper testbench: level table over APB, faults, short latch, sleep, off time.
   Assumes the bound checker and the winding model. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, pump_en_o, translator_home_o;
	logic off_time_strapped_i = 1'b1;
	logic sleep_n_i = 1'b1;
	logic [1:0] trip_i, zero_cur_i;
	logic [1:0] gnd_short_i = 2'h0;
	logic [3:0] flt = 4'h0;
	logic [1:0][1:0] dac_level_o;
	bcc_pkg::bcc_gate_s [1:0] gate_o;
	logic [11:0] rows [4] = '{12'h0dd, 12'h066, 12'h0bb, 12'h000};
	int failures = 0;
	int n_tests = 0;
	int n;
	bcc_chopper i_dut (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .phase_i(2'h1), .trip_i, .zero_cur_i, .gnd_short_i,
		.off_time_strapped_i, .off_time_ohms_i(20'h0203a), .sleep_n_i,
		.sink_gate_regulator_fault_i(flt[0]), .over_temp_i(flt[1]),
		.gate_pump_reservoir_uv_i(flt[2]), .supply_undervoltage_lockout_i(flt[3]), .gate_o,
		.dac_level_o, .pump_en_o, .translator_home_o);
	bcc_motor_model #(.RAMP(40)) i_wind (.clk_sys_i, .gate_i(gate_o), .phase_i(2'h1),
		.trip_o(trip_i), .zero_cur_o(zero_cur_i));
	task automatic wt(input int c);
		repeat (c) @(posedge clk_sys_i);
	endtask : wt
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		wt(1);
		penable_i <= 1'b1;
		// Look mid-cycle so the answer is seen settled before the edge that takes it
		@(negedge clk_sys_i);
		while (pready_o !== 1'b1) begin
			@(negedge clk_sys_i);
		end
		rd = prdata_o;
		wt(1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		wt(1);
	endtask : apb
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	initial forever #5 clk_sys_i = ~clk_sys_i;
	initial begin
		wt(20000);
		failures++;
		tally_and_finish();
	end
	initial begin
		wt(8);
		rst_n_i <= 1'b1;
		wt(3);
		foreach (rows[i]) begin
			apb(1'b1, bcc_pkg::ADDR_CTRL, {24'h0, rows[i][11:4]});
			apb(1'b0, bcc_pkg::ADDR_CTRL, 32'h0);
			cmp("ctrl", {24'h0, rows[i][11:4]}, rd);
			cmp("level", {28'h0, rows[i][3:0]}, {28'h0, dac_level_o});
		end
		apb(1'b1, 8'h3c, 32'hffffffff);
		apb(1'b0, 8'h3c, 32'h0);
		cmp("unmapped", 32'h0, rd);
		wt(7000);
		$display("test done: levels, map, strapped chopping");
		for (int i = 0; i < 4; i++) begin
			flt <= 4'h1 << i;
			wt(3);
			cmp("fault", {23'h0, flt[3], 8'h00}, {23'h0, translator_home_o, gate_o});
			flt <= 4'h0;
			wt(4);
			cmp("resume", 32'h69, {24'h0, gate_o});
		end
		gnd_short_i <= 2'h2;
		wt(2);
		gnd_short_i <= 2'h0;
		wt(5);
		cmp("short latch", 32'h09, {24'h0, gate_o});
		sleep_n_i <= 1'b0;
		off_time_strapped_i <= 1'b0;
		wt(3);
		cmp("sleep", 32'h0, {23'h0, pump_en_o, gate_o});
		sleep_n_i <= 1'b1;
		wt(4);
		cmp("wake", 32'h169, {23'h0, pump_en_o, gate_o});
		// No register command after the wake, so the wait for fast decay times the pin-set off time
		while (gate_o[0] !== 4'h6) wt(1);
		for (n = 0; gate_o[0] === 4'h6; n++) wt(1);
		cmp("fast span", 8250 * 100 / 825 * 5 / 16, n);
		for (n = 0; gate_o[0] === 4'h5; n++) wt(1);
		cmp("slow span", 1000 - 312, n);
		$display("test done: faults, short, sleep, off time");
		rst_n_i <= 1'b0;
		wt(2);
		cmp("reset", 32'h1, {20'h0, pready_o, |prdata_o, gate_o, pump_en_o, translator_home_o});
		$display("test done: reset");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
